// >>> rtl/fsc_top.sv
// fault reporting, status readback, frame checking and clear control
// assumes host drives sclk/sync_n/sdi asynchronously; fault detectors are async levels
`timescale 1ns/1ns
`include "fsc_map.svh"
module fsc_top (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              sclk,
  input  wire logic              sync_n,
  input  wire logic              sdi,
  output logic                   sdo_out,
  output logic                   sdo_oe,
  input  wire logic [2:0]        device_address,
  input  wire logic              hw_mode_pin,
  input  wire logic [3:0]        range_code_pin,
  input  wire logic              sense_resistor_pin,
  input  wire logic              clear_value_select_pin,
  input  wire logic              clear_pin,
  input  wire logic              open_loop_det,
  input  wire logic              headroom_low_det,
  input  wire logic              vshort_det,
  input  wire logic              overtemp_det,
  output logic                   fault_alert_n_out,
  output logic                   fault_alert_n_oe,
  output logic                   current_alert_n_out,
  output logic                   current_alert_n_oe,
  output logic                   voltage_alert_n_out,
  output logic                   voltage_alert_n_oe,
  output logic                   thermal_alert_n_out,
  output logic                   thermal_alert_n_oe,
  output logic [3:0]             range_code,
  output logic                   sense_resistor_select,
  output logic                   output_drive_enable,
  output logic                   clear_active,
  output logic                   current_clear_bottom,
  output fsc_pkg::fsc_vclear_t   vclear_code
);
  localparam int NPIN = 15;

  fsc_link_if lnk ();

  logic [NPIN-1:0]             pin_s1_q;
  logic [NPIN-1:0]             pin_s2_q;
  logic [2:0]                  addr_s;
  logic                        hw_s;
  logic [3:0]                  range_s;
  logic                        res_sel_s;
  logic                        clr_sel_s;
  logic                        clear_s;
  logic                        open_s;
  logic                        head_s;
  logic                        vshort_s;
  logic                        ot_s;
  logic [1:0]                  strap_cnt_q;
  logic                        hw_q;
  fsc_pkg::fsc_state_t         state_q;
  logic [4:0]                  cnt_q;
  logic [`FSC_SHIFT_W-1:0]     shift_q;
  logic [2:0]                  rise_q;
  logic                        rd_q;
  logic [`FSC_WORD_W-1:0]      tx_q;
  logic [`FSC_CRC_W-1:0]       crc;
  logic [`FSC_WORD_W-1:0]      data_w;
  logic                        ok16;
  logic                        ok24;
  logic                        bad24;
  logic                        addr_hit;
  logic                        wr;
  logic                        rd_req;
  logic [3:0]                  range_q;
  logic                        clr_sel_q;
  logic                        drv_en_q;
  logic                        res_sel_q;
  logic                        clr_cmd_q;
  logic                        crc_err_q;
  logic                        iflt;
  logic                        any_fault;
  logic [3:0]                  range_eff;
  logic                        clr_sel_eff;
  logic [`FSC_WORD_W-1:0]      rb_word;
  fsc_pkg::fsc_vclear_t        vclear_d;

  // ---------------------------------------------
  // link front end and frame check
  // ---------------------------------------------
  fsc_link_rx u_rx (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .sclk    (sclk),
    .sync_n  (sync_n),
    .sdi     (sdi),
    .lnk     (lnk.src)
  );

  // crc runs over the first sixteen bits only
  fsc_crc8 u_crc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clr     (lnk.frame_start),
    .en      (state_q == fsc_pkg::FSC_ST_SHIFT && lnk.sclk_fall &&
              cnt_q < `FSC_FRAME_PLAIN),
    .din     (lnk.bit_val),
    .crc     (crc)
  );

  // ---------------------------------------------
  // pin synchronisers and mode strap
  // ---------------------------------------------
  // all static pins and detector levels pass two flops
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {device_address, hw_mode_pin, range_code_pin, sense_resistor_pin,
                   clear_value_select_pin, clear_pin, open_loop_det,
                   headroom_low_det, vshort_det, overtemp_det};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {addr_s, hw_s, range_s, res_sel_s, clr_sel_s, clear_s,
          open_s, head_s, vshort_s, ot_s} = pin_s2_q;

  // mode is caught once after reset release, then frozen
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_cnt_q <= 2'h0;
      hw_q        <= 1'b0;
    end
    else if (strap_cnt_q != `FSC_STRAP_WAIT)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      hw_q        <= hw_s;
    end
  end

  // ---------------------------------------------
  // frame receiver
  // ---------------------------------------------
  // bits taken on falling serial clock; count saturates on long frames
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= fsc_pkg::FSC_ST_IDLE;
      cnt_q   <= 5'h00;
      shift_q <= '0;
    end
    else
    begin
      case (state_q)
        fsc_pkg::FSC_ST_IDLE:
        begin
          if (lnk.frame_start)
          begin
            state_q <= fsc_pkg::FSC_ST_SHIFT;
            cnt_q   <= 5'h00;
          end
        end
        fsc_pkg::FSC_ST_SHIFT:
        begin
          if (lnk.frame_end)
            state_q <= fsc_pkg::FSC_ST_IDLE;
          else if (lnk.sclk_fall)
          begin
            shift_q <= {shift_q[`FSC_SHIFT_W-2:0], lnk.bit_val};
            if (cnt_q != `FSC_CNT_MAX)
              cnt_q <= cnt_q + 5'h01;
          end
        end
        default:
          state_q <= fsc_pkg::FSC_ST_IDLE;
      endcase
    end
  end

  // frame verdict at the rising frame select
  assign data_w   = (cnt_q == `FSC_FRAME_CRC) ? shift_q[`FSC_SHIFT_W-1:`FSC_CRC_W]
                                              : shift_q[`FSC_WORD_W-1:0];
  assign ok16     = (cnt_q == `FSC_FRAME_PLAIN);
  assign ok24     = (cnt_q == `FSC_FRAME_CRC) && (crc == shift_q[7:0]);
  assign bad24    = (cnt_q == `FSC_FRAME_CRC) && (crc != shift_q[7:0]);
  assign addr_hit = (data_w[`FSC_ADDR_HI:`FSC_ADDR_LO] == addr_s);
  assign wr       = lnk.frame_end && (ok16 || ok24) && addr_hit && !data_w[`FSC_RW_BIT];
  assign rd_req   = (cnt_q >= `FSC_RD_CMD_LEN) && (shift_q[3:1] == addr_s) && shift_q[0];

  // ---------------------------------------------
  // control register
  // ---------------------------------------------
  // writes land even while clear holds, so release shows the new value
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      range_q   <= `FSC_RANGE_RST;
      clr_sel_q <= 1'b0;
      drv_en_q  <= 1'b0;
      res_sel_q <= 1'b0;
      clr_cmd_q <= 1'b0;
    end
    else
    begin
      clr_cmd_q <= wr && data_w[`FSC_CLRCMD_BIT] && !data_w[`FSC_SWRST_BIT];
      if (wr && data_w[`FSC_SWRST_BIT])
      begin
        range_q   <= `FSC_RANGE_RST;
        clr_sel_q <= 1'b0;
        drv_en_q  <= 1'b0;
        res_sel_q <= 1'b0;
      end
      else if (wr)
      begin
        range_q   <= data_w[`FSC_RANGE_HI:`FSC_RANGE_LO];
        clr_sel_q <= data_w[`FSC_CLR_SEL_BIT];
        drv_en_q  <= data_w[`FSC_DRV_EN_BIT];
        res_sel_q <= data_w[`FSC_RES_SEL_BIT];
      end
    end
  end

  // ---------------------------------------------
  // status flags and readback
  // ---------------------------------------------
  // a new crc failure wins over the read that would clear it
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      crc_err_q <= 1'b0;
    else if (lnk.frame_end && bad24)
      crc_err_q <= 1'b1;
    else if (lnk.frame_end && rd_q)
      crc_err_q <= 1'b0;
  end

  assign iflt        = open_s | head_s;
  assign any_fault   = iflt | vshort_s | ot_s | crc_err_q;
  assign range_eff   = hw_q ? range_s : range_q;
  assign clr_sel_eff = clr_sel_s | clr_sel_q;
  assign rb_word     = {addr_s, `FSC_RD_FIXED, range_eff, clr_sel_eff, drv_en_q,
                        (hw_q ? res_sel_s : res_sel_q), crc_err_q, ot_s, iflt, vshort_s};

  // readback shifts out from the fifth rising edge, released at frame end
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rise_q  <= 3'h0;
      rd_q    <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
      tx_q    <= '0;
    end
    else if (lnk.frame_start)
    begin
      rise_q <= 3'h0;
      rd_q   <= 1'b0;
    end
    else if (lnk.frame_end)
    begin
      rd_q    <= 1'b0;
      sdo_oe  <= 1'b0;
      sdo_out <= 1'b0;
    end
    else if (state_q == fsc_pkg::FSC_ST_SHIFT && lnk.sclk_rise)
    begin
      if (rise_q != `FSC_RISE_MAX)
        rise_q <= rise_q + 3'h1;
      if (rise_q == `FSC_RD_RISE_PRIOR && rd_req && !rd_q)
      begin
        rd_q    <= 1'b1;
        sdo_oe  <= 1'b1;
        sdo_out <= rb_word[`FSC_WORD_W-1];
        tx_q    <= {rb_word[`FSC_WORD_W-2:0], 1'b0};
      end
      else if (rd_q)
      begin
        sdo_out <= tx_q[`FSC_WORD_W-1];
        tx_q    <= {tx_q[`FSC_WORD_W-2:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------
  // alerts and clear outputs
  // ---------------------------------------------
  // voltage clear target from polarity of the live range
  always_comb
  begin
    if (!clr_sel_eff)
      vclear_d = fsc_pkg::fsc_is_bipolar(range_eff) ? fsc_pkg::FSC_VCLR_NEGFS
                                                    : fsc_pkg::FSC_VCLR_ZERO;
    else
      vclear_d = fsc_pkg::fsc_is_bipolar(range_eff) ? fsc_pkg::FSC_VCLR_ZERO
                                                    : fsc_pkg::FSC_VCLR_MID;
  end

  // open-drain pins only ever pull low; the enable carries the fault
  assign fault_alert_n_out   = 1'b0;
  assign current_alert_n_out = 1'b0;
  assign voltage_alert_n_out = 1'b0;
  assign thermal_alert_n_out = 1'b0;

  // registered so pins never glitch on detector chatter
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fault_alert_n_oe      <= 1'b0;
      current_alert_n_oe    <= 1'b0;
      voltage_alert_n_oe    <= 1'b0;
      thermal_alert_n_oe    <= 1'b0;
      clear_active          <= 1'b0;
      current_clear_bottom  <= 1'b0;
      vclear_code           <= fsc_pkg::FSC_VCLR_ZERO;
      range_code            <= `FSC_RANGE_RST;
      sense_resistor_select <= 1'b0;
      output_drive_enable   <= 1'b0;
    end
    else
    begin
      fault_alert_n_oe      <= !hw_q && any_fault;
      current_alert_n_oe    <= hw_q && iflt;
      voltage_alert_n_oe    <= hw_q && vshort_s;
      thermal_alert_n_oe    <= hw_q && ot_s;
      clear_active          <= clear_s || clr_cmd_q;
      current_clear_bottom  <= clear_s || clr_cmd_q;
      vclear_code           <= vclear_d;
      range_code            <= range_eff;
      sense_resistor_select <= hw_q ? res_sel_s : res_sel_q;
      output_drive_enable   <= drv_en_q;
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence seq_bad_frame;
    lnk.frame_end && bad24;
  endsequence
  sequence seq_read_done;
    lnk.frame_end && rd_q && !bad24;
  endsequence

  AST_CRC_ERR_SET: assert property (seq_bad_frame |=> crc_err_q)
    else $error("crc failure did not set the frame check flag");
  AST_CRC_ERR_AUTOCLR: assert property (seq_read_done |=> !crc_err_q)
    else $error("status read did not clear the frame check flag");
  AST_BAD_NO_WRITE: assert property (seq_bad_frame |=> $stable(range_q) && $stable(drv_en_q))
    else $error("failed frame changed the control register");
  AST_WRITE16: assert property (lnk.frame_end && ok16 && addr_hit && !data_w[`FSC_RW_BIT]
    && !data_w[`FSC_SWRST_BIT] |=> range_q == $past(data_w[`FSC_RANGE_HI:`FSC_RANGE_LO]))
    else $error("plain frame not written");
  AST_SW_ALERT: assert property (!hw_q && crc_err_q ##1 crc_err_q |-> fault_alert_n_oe)
    else $error("combined alert not pulled low");
  AST_HW_IALERT: assert property (hw_q && iflt |=> current_alert_n_oe && !fault_alert_n_oe)
    else $error("current alert wrong in hardware mode");
  AST_HW_TALERT: assert property (overtemp_det[*4] ##0 hw_q |-> thermal_alert_n_oe)
    else $error("thermal alert missing");
  AST_OT_FLAG: assert property (overtemp_det[*3] |-> rb_word[`FSC_OTEMP_BIT])
    else $error("overheat flag missing in readback");
  AST_CLEAR: assert property (clear_pin[*4] |-> clear_active && current_clear_bottom)
    else $error("clear input did not force clear");
  AST_CLEAR_VALUE_SELECT: assert property (clear_value_select_pin[*4] |->
    vclear_code != fsc_pkg::FSC_VCLR_NEGFS)
    else $error("clear select pin ignored");
  AST_SDO_RELEASE: assert property (lnk.frame_end |=> !sdo_oe)
    else $error("data output not released at frame end");
endmodule : fsc_top

// >>> rtl/fsc_map.svh
// offsets, field positions, frame lengths and timing counts of the fault/clear block
// assumes nothing; included by the package users by bare name
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

`define FSC_WORD_W        16
`define FSC_CRC_W         8
`define FSC_SHIFT_W       24
`define FSC_FRAME_PLAIN   5'h10
`define FSC_FRAME_CRC     5'h18
`define FSC_RD_CMD_LEN    5'h04
`define FSC_RD_RISE_PRIOR 3'h4
`define FSC_RISE_MAX      3'h7
`define FSC_CNT_MAX       5'h1F
`define FSC_ADDR_HI       15
`define FSC_ADDR_LO       13
`define FSC_RW_BIT        12
`define FSC_RANGE_HI      10
`define FSC_RANGE_LO      7
`define FSC_CLR_SEL_BIT   6
`define FSC_DRV_EN_BIT    5
`define FSC_RES_SEL_BIT   4
`define FSC_CRC_ERR_BIT   3
`define FSC_OTEMP_BIT     2
`define FSC_IFLT_BIT      1
`define FSC_VFLT_BIT      0
`define FSC_CLRCMD_BIT    3
`define FSC_SWRST_BIT     2
`define FSC_RD_FIXED      2'h2
`define FSC_RANGE_RST     4'h0
`define FSC_CRC_POLY      8'h07
`define FSC_CRC_INIT      8'h00
`define FSC_STRAP_WAIT    2'h3

`endif

// >>> rtl/fsc_pkg.sv
// types shared by the fault/clear block
// assumes fsc_map.svh is on the include path
package fsc_pkg;

  // frame receiver states
  typedef enum logic [1:0] {
    FSC_ST_IDLE  = 2'b01,
    FSC_ST_SHIFT = 2'b10
  } fsc_state_t;

  // voltage clear target
  typedef enum logic [2:0] {
    FSC_VCLR_ZERO  = 3'b001,
    FSC_VCLR_NEGFS = 3'b010,
    FSC_VCLR_MID   = 3'b100
  } fsc_vclear_t;

  // bipolar voltage range codes
  function automatic logic fsc_is_bipolar(input logic [3:0] code);
    fsc_is_bipolar = (code == 4'h7) || (code == 4'h8) || (code == 4'hB) ||
                     (code == 4'hC) || (code == 4'hD);
  endfunction : fsc_is_bipolar

endpackage : fsc_pkg

// >>> rtl/fsc_link_if.sv
// synchronised serial link strobes between the receiver front end and the core
// assumes both ends run on clk_sys
`timescale 1ns/1ns
interface fsc_link_if;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;
  logic bit_val;

  modport src (output frame_start, output frame_end, output sclk_rise,
               output sclk_fall, output bit_val);
  modport dst (input frame_start, input frame_end, input sclk_rise,
               input sclk_fall, input bit_val);
endinterface : fsc_link_if

// >>> rtl/fsc_crc8.sv
// serial crc-8 over the received data bits, msb first
// assumes en pulses once per data bit, clr at each frame start
`timescale 1ns/1ns
`include "fsc_map.svh"
module fsc_crc8 #(
  parameter int                W    = `FSC_CRC_W,
  parameter logic [W-1:0]      POLY = `FSC_CRC_POLY
) (
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  input  wire logic            clr,
  input  wire logic            en,
  input  wire logic            din,
  output logic     [W-1:0]     crc
);
  // ---------------------------------------------
  // shift register
  // ---------------------------------------------
  // lfsr step: feedback is msb xor incoming bit
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      crc <= W'(`FSC_CRC_INIT);
    else if (clr)
      crc <= W'(`FSC_CRC_INIT);
    else if (en)
      crc <= {crc[W-2:0], 1'b0} ^ ((crc[W-1] ^ din) ? POLY : '0);
  end
endmodule : fsc_crc8

// >>> rtl/fsc_link_rx.sv
// serial link front end: synchronises clock, frame select and data, finds edges
// assumes link clock slow against clk_sys (at least four cycles per phase)
`timescale 1ns/1ns
module fsc_link_rx (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic sclk,
  input  wire logic sync_n,
  input  wire logic sdi,
  fsc_link_if.src   lnk
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [1:0] prev_q;

  // ---------------------------------------------
  // two-stage synchronisers
  // ---------------------------------------------
  // data rides with the clock so bit and edge stay aligned
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q   <= 3'h3;
      s2_q   <= 3'h3;
      prev_q <= 2'h1;  // idle levels: clock low, frame select high, no false edge
    end
    else
    begin
      s1_q   <= {sclk, sync_n, sdi};
      s2_q   <= s1_q;
      prev_q <= s2_q[2:1];
    end
  end

  // edge strobes from settled samples only
  assign lnk.sclk_rise   =  s2_q[2] & ~prev_q[1];
  assign lnk.sclk_fall   = ~s2_q[2] &  prev_q[1];
  assign lnk.frame_start = ~s2_q[1] &  prev_q[0];
  assign lnk.frame_end   =  s2_q[1] & ~prev_q[0];
  assign lnk.bit_val     =  s2_q[0];
endmodule : fsc_link_rx

// >>> sim/fsc_host_model.sv
// host side of the serial link: frames words, adds crc, samples readback
// assumes clk_sys paces it and xfer is called between frames only
`timescale 1ns/1ns
module fsc_host_model (
  input  wire logic clk_sys,
  output logic      sclk,
  output logic      sync_n,
  output logic      sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  // ------------------------------
  // link driver
  // ------------------------------
  // idle: clock parked low, frame select high
  initial
  begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  // crc-8 over the word, msb first, init zero
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  // four clk_sys per phase gives the 400 ns link clock
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask : half
  // n bits msb first; bad spoils the crc; sdo taken on falls 5..20
  task automatic xfer(input logic [15:0] w, input int n, input logic bad,
                      output logic [15:0] rd);
    logic [23:0] f;
    f = {w, crc8(w) ^ {8{bad}}};
    rd = 16'h0000;
    sync_n = 1'b0;
    half();
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      sdi = f[23-i];
      half();
      if (i >= 4 && i < 20)
        rd[19-i] = sdo_oe ? sdo_out : 1'bx;
      sclk = 1'b0;
      half();
    end
    sync_n = 1'b1;
    sdi = ~sdi; // released line must not show a stale bit
    half();
    half();
  endtask : xfer
endmodule : fsc_host_model

// >>> sim/fsc_top_tb_top.sv
// bench for fsc_top: writes, reads, crc, faults, clear, hardware mode
// assumes fsc_host_model on the link; alert wires have a pull-up
`timescale 1ns/1ns
module fsc_top_tb_top;
  // ------------------------------
  // signals and instances
  // ------------------------------
  localparam logic [2:0] ADR = 3'h5;
  logic                 clk_sys = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 hw_mode_pin = 1'b0;
  logic [3:0]           range_code_pin = 4'h0;
  logic                 sense_resistor_pin = 1'b0;
  logic                 clear_value_select_pin = 1'b0;
  logic                 clear_pin = 1'b0;
  logic [3:0]           det = 4'h0;
  wire logic [3:0]      a_out, a_oe;
  logic [3:0]           range_code;
  logic                 sense_resistor_select, output_drive_enable;
  logic                 clear_active, current_clear_bottom, clr_q = 1'b0;
  fsc_pkg::fsc_vclear_t vclear_code;
  wire logic            sclk, sync_n, sdi, sdo_out, sdo_oe;
  logic [15:0]          rd;
  logic [6:0]           ctl_e;
  int                   bad_count = 0, check_count = 0, clr_seen = 0;
  // wire level: combined, current, voltage, thermal
  wire logic [3:0]      alw = ~a_oe | a_out;
  fsc_top dut (
    .clk_sys, .sys_rst, .sclk, .sync_n, .sdi, .sdo_out, .sdo_oe,
    .device_address(ADR), .hw_mode_pin, .range_code_pin, .sense_resistor_pin,
    .clear_value_select_pin, .clear_pin, .open_loop_det(det[0]),
    .headroom_low_det(det[1]), .vshort_det(det[2]), .overtemp_det(det[3]),
    .fault_alert_n_out(a_out[3]), .fault_alert_n_oe(a_oe[3]),
    .current_alert_n_out(a_out[2]), .current_alert_n_oe(a_oe[2]),
    .voltage_alert_n_out(a_out[1]), .voltage_alert_n_oe(a_oe[1]),
    .thermal_alert_n_out(a_out[0]), .thermal_alert_n_oe(a_oe[0]),
    .range_code, .sense_resistor_select, .output_drive_enable,
    .clear_active, .current_clear_bottom, .vclear_code
  );
  fsc_host_model host (.clk_sys, .sclk, .sync_n, .sdi, .sdo_out, .sdo_oe);
  always #25 clk_sys = ~clk_sys;
  // counts clear rises so a one-cycle command clear is not missed
  always @(posedge clk_sys)
  begin
    clr_q <= clear_active;
    if (clear_active === 1'b1 && clr_q !== 1'b1)
      clr_seen <= clr_seen + 1;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
      $display("[ERR] %0t mismatch got %h exp %h (%0d)", $time, g, e, ++bad_count);
  endtask : chk
  task automatic idle(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : idle
  function automatic logic [15:0] wd(input logic [6:0] c, input logic cmd);
    return {ADR, 2'b00, c, cmd, 3'b000};
  endfunction : wd
  // read frame with valid crc, compare whole word
  task automatic rb(input logic [3:0] fl);
    host.xfer({ADR, 13'h1000}, 24, 1'b0, rd);
    chk(rd, {ADR, 2'b10, ctl_e[6:3], ctl_e[2] | clear_value_select_pin, ctl_e[1:0], fl});
    chk(16'(sdo_oe), 16'h0);
  endtask : rb
  task automatic t_wr();
    ctl_e = {4'h3, 3'b011};
    host.xfer(wd(ctl_e, 1'b0), 16, 1'b0, rd);
    chk(16'(range_code), 16'h3);
    chk(16'({sense_resistor_select, output_drive_enable}), 16'h3);
    rb(4'h0);
    $display("write test done");
  endtask : t_wr
  task automatic t_crc();
    ctl_e = {4'hB, 3'b011};
    host.xfer(wd(ctl_e, 1'b0), 24, 1'b0, rd);
    chk(16'(range_code), 16'hB);
    host.xfer(wd(7'h13, 1'b0), 24, 1'b1, rd);
    chk(16'(range_code), 16'hB);
    chk(16'(alw), 16'h7);
    rb(4'h8);
    chk(16'(alw), 16'hF);
    rb(4'h0);
    $display("crc test done");
  endtask : t_crc
  task automatic t_flt();
    for (int i = 0; i < 4; i++)
    begin
      det = 4'h1 << i;
      idle(6);
      chk(16'(alw), 16'h7);
      rb({1'b0, det[3], det[0] | det[1], det[2]});
    end
    det = 4'h0;
    idle(6);
    chk(16'(alw), 16'hF);
    $display("fault test done");
  endtask : t_flt
  task automatic t_clr();
    int n;
    clear_pin = 1'b1;
    idle(6);
    chk(16'({clear_active, current_clear_bottom}), 16'h3);
    chk(16'(vclear_code), 16'(fsc_pkg::FSC_VCLR_NEGFS));
    clear_value_select_pin = 1'b1;
    idle(6);
    chk(16'(vclear_code), 16'(fsc_pkg::FSC_VCLR_ZERO));
    ctl_e = {4'h3, 3'b011};
    host.xfer(wd(ctl_e, 1'b0), 16, 1'b0, rd);
    chk(16'(vclear_code), 16'(fsc_pkg::FSC_VCLR_MID));
    clear_value_select_pin = 1'b0;
    idle(6);
    chk(16'(vclear_code), 16'(fsc_pkg::FSC_VCLR_ZERO));
    clear_pin = 1'b0;
    idle(6);
    chk(16'({clear_active, range_code}), 16'h3);
    n = clr_seen;
    ctl_e = {4'h3, 3'b111};
    host.xfer(wd(ctl_e, 1'b1), 16, 1'b0, rd);
    chk(16'(clr_seen - n), 16'h1);
    rb(4'h0);
    $display("clear test done");
  endtask : t_clr
  task automatic t_hw();
    hw_mode_pin = 1'b1;
    range_code_pin = 4'hC;
    sense_resistor_pin = 1'b1;
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    idle(8);
    chk(16'({range_code, sense_resistor_select}), 16'h19);
    for (int i = 0; i < 4; i++)
    begin
      det = 4'h1 << i;
      idle(6);
      chk(16'(alw), 16'({1'b1, ~(det[0] | det[1]), ~det[2], ~det[3]}));
    end
    det = 4'h0;
    $display("hardware mode test done");
  endtask : t_hw
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // main sequence: reset two cycles, then the tests in order
  initial
  begin
    idle(2);
    sys_rst = 1'b0;
    idle(4);
    t_wr();
    t_crc();
    t_flt();
    t_clr();
    t_hw();
    give_verdict();
  end
  // watchdog well past the expected run of about 0.13 ms
  initial
  begin
    #2000000;
    $display("[ERR] %0t watchdog expired (%0d)", $time, ++bad_count);
    give_verdict();
  end
endmodule : fsc_top_tb_top
